// [hdl/energy_preset_defs.vh]
// Constants of the energy preset and reset register bank
// Overview of operation
// - LEAD reactive preset: low half at 0x178, high half at 0x179.
// - LAG reactive preset: low half at 0x17A, high half at 0x17B.
// - Writing 1 at 0x17C applies LEAD and LAG staged words; other values ignored.
// - Apparent preset: low half at 0x17D, high half at 0x17E.
// - Writing 1 at 0x17F loads apparent preset; other values ignored.
// - Preset limit follows rated power times VT and CT ratios, four bands; the bank bands rated_power_w as given, with no ratio scaling.
// - Writing 1 at 0x18F resets the device; other values ignored; reads zero.
// - Remote reset pulses device reset, measurement clear and optional integration stop; extremes are not cleared.
// - Remote reset leaves energy counters and configured parameters untouched.
// - Writing 1 to the extremes clear register clears maximum and minimum values.
// - Accepted write is answered with station number and OK, STX/ETX framed.
`ifndef ENERGY_PRESET_DEFS_VH
`define ENERGY_PRESET_DEFS_VH

// ******
// Register offsets
// ******
`define ADDR_LEAD_LO        16'h0178
`define ADDR_LEAD_HI        16'h0179
`define ADDR_LAG_LO         16'h017A
`define ADDR_LAG_HI         16'h017B
`define ADDR_REACT_COMMIT   16'h017C
`define ADDR_APP_LO         16'h017D
`define ADDR_APP_HI         16'h017E
`define ADDR_APP_COMMIT     16'h017F
`define ADDR_REMOTE_RESET   16'h018F
`define ADDR_EXTREMES_CLEAR 16'h015E

// ******
// Values and reset values
// ******
`define COMMIT_VALUE        16'h0001
`define STAGE_RESET         16'h0000
`define READ_ZERO           16'h0000

// ******
// Preset range bands (power in watts)
// ******
`define POWER_STEP_0        32'h000186A0
`define POWER_STEP_1        32'h000F4240
`define POWER_STEP_2        32'h00989680
`define LIMIT_BAND_0        32'h0001869F
`define LIMIT_BAND_1        32'h000F423F
`define LIMIT_BAND_2        32'h0098967F
`define LIMIT_BAND_3        32'h05F5E0FF

// ******
// Timing
// ******
`define CLK_KHZ             50000
`define RESET_WAIT_MS       10000

// ******
// Response framing characters
// ******
`define CHAR_STX            8'h02
`define CHAR_ETX            8'h03
`define CHAR_CR             8'h0D
`define CHAR_O              8'h4F
`define CHAR_K              8'h4B
`define CHAR_CPU_HI         8'h30
`define CHAR_CPU_LO         8'h31
`define CHAR_DIGIT_BASE     8'h30
`define CHAR_ALPHA_BASE     8'h37

`endif

// [hdl/preset_range_check.v]
// Range check of a 32-bit energy preset against the rated power band
`timescale 1ns/1ns
`default_nettype none
`include "energy_preset_defs.vh"

module preset_range_check (
    input  wire [31:0] preset_value,
    input  wire [31:0] rated_power_w,
    output wire        in_range
);

    // ******
    // Band selection
    // ******
    reg [31:0] limit;

    // Pick the limit for the power band
    always @* begin
        if (rated_power_w < `POWER_STEP_0) begin
            limit = `LIMIT_BAND_0;
        end else if (rated_power_w < `POWER_STEP_1) begin
            limit = `LIMIT_BAND_1;
        end else if (rated_power_w < `POWER_STEP_2) begin
            limit = `LIMIT_BAND_2;
        end else begin
            limit = `LIMIT_BAND_3;
        end
    end

    assign in_range = (preset_value <= limit);

endmodule // preset_range_check

`default_nettype wire

// [hdl/ok_response_tx.v]
// Byte sequencer for the framed OK acknowledgement
`timescale 1ns/1ns
`default_nettype none
`include "energy_preset_defs.vh"

module ok_response_tx (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       start,
    input  wire [7:0] station,
    input  wire       tx_ready,
    output reg  [7:0] tx_data_reg,
    output wire       tx_valid,
    output wire       busy
);

    // ******
    // Sequencer state
    // ******
    localparam IDLE = 1'b0;
    localparam SEND = 1'b1;
    localparam LAST = 3'd7;

    reg       state_reg;
    reg [2:0] index_reg;

    // Hex digit to ASCII
    function [7:0] to_ascii;
        input [3:0] nib;
        begin
            if (nib < 4'hA) begin
                to_ascii = `CHAR_DIGIT_BASE + {4'h0, nib};
            end else begin
                to_ascii = `CHAR_ALPHA_BASE + {4'h0, nib};
            end
        end
    endfunction

    // Byte of the frame at a position
    function [7:0] frame_byte;
        input [2:0] idx;
        input [7:0] st;
        begin
            case (idx)
                3'd0:    frame_byte = `CHAR_STX;
                3'd1:    frame_byte = to_ascii(st[7:4]);
                3'd2:    frame_byte = to_ascii(st[3:0]);
                3'd3:    frame_byte = `CHAR_CPU_HI;
                3'd4:    frame_byte = `CHAR_CPU_LO;
                3'd5:    frame_byte = `CHAR_O;
                3'd6:    frame_byte = `CHAR_K;
                default: frame_byte = `CHAR_ETX;
            endcase
        end
    endfunction

    reg [7:0] station_reg;

    assign tx_valid = (state_reg == SEND);
    assign busy     = (state_reg == SEND);

    // Walk STX, station, CPU, OK, ETX, CR
    always @(posedge clk) begin
        if (sys_rst) begin
            state_reg   <= IDLE;
            index_reg   <= 3'd0;
            tx_data_reg <= 8'h00;
            station_reg <= 8'h00;
        end else begin
            case (state_reg)
                IDLE: begin
                    if (start) begin
                        state_reg   <= SEND;
                        index_reg   <= 3'd0;
                        station_reg <= station;
                        tx_data_reg <= `CHAR_STX;
                    end
                end
                default: begin
                    if (tx_ready) begin
                        if (tx_data_reg == `CHAR_CR) begin
                            state_reg <= IDLE;
                        end else if (index_reg == LAST) begin
                            tx_data_reg <= `CHAR_CR;
                        end else begin
                            index_reg   <= index_reg + 3'd1;
                            tx_data_reg <= frame_byte(index_reg + 3'd1, station_reg);
                        end
                    end
                end
            endcase
        end
    end

endmodule // ok_response_tx

`default_nettype wire

// [hdl/energy_preset_regs.v]
// Energy preset staging, commit and remote reset register bank
`timescale 1ns/1ns
`default_nettype none
`include "energy_preset_defs.vh"

module energy_preset_regs #(
    parameter [31:0] RESET_WAIT_CYCLES = `RESET_WAIT_MS * `CLK_KHZ
) (
    input  wire        clk,
    input  wire        sys_rst,
    // Decoded register write from the command parser
    input  wire        wr_valid,
    input  wire [15:0] wr_addr,
    input  wire [15:0] wr_data,
    input  wire        wr_last,
    output wire        wr_ready,
    // Register read
    input  wire        rd_valid,
    input  wire [15:0] rd_addr,
    output reg  [15:0] rd_data_reg,
    output reg         rd_ack_reg,
    // Response byte stream
    input  wire [7:0]  station,
    input  wire        tx_ready,
    output wire [7:0]  tx_data,
    output wire        tx_valid,
    // Configuration from same-clock logic
    input  wire [31:0] rated_power_w,
    // Counter preset loads
    output reg  [31:0] lead_preset_reg,
    output reg         lead_load_reg,
    output reg  [31:0] lag_preset_reg,
    output reg         lag_load_reg,
    output reg  [31:0] apparent_preset_reg,
    output reg         apparent_load_reg,
    output reg         preset_reject_reg,
    // Reset actions
    output reg         device_reset_reg,
    output reg         meas_clear_reg,
    output reg         opt_integ_stop_reg,
    output reg         extremes_clear_reg,
    output wire        reset_busy
);

    // ******
    // Staging registers
    // ******
    reg [15:0] lead_lo_reg;
    reg [15:0] lead_hi_reg;
    reg [15:0] lag_lo_reg;
    reg [15:0] lag_hi_reg;
    reg [15:0] app_lo_reg;
    reg [15:0] app_hi_reg;
    reg        cmd_bad_reg;
    reg [31:0] reset_wait_reg;

    wire        wr_take;
    wire        resp_busy;
    wire        resp_start;
    wire        lead_ok;
    wire        lag_ok;
    wire        app_ok;
    wire [31:0] lead_staged;
    wire [31:0] lag_staged;
    wire [31:0] app_staged;
    wire        commit_one;

    // True for every offset the bank answers
    function addr_mapped;
        input [15:0] a;
        begin
            if (a == `ADDR_LEAD_LO) begin
                addr_mapped = 1'b1;
            end else if (a == `ADDR_LEAD_HI) begin
                addr_mapped = 1'b1;
            end else if (a == `ADDR_LAG_LO) begin
                addr_mapped = 1'b1;
            end else if (a == `ADDR_LAG_HI) begin
                addr_mapped = 1'b1;
            end else if (a == `ADDR_REACT_COMMIT) begin
                addr_mapped = 1'b1;
            end else if (a == `ADDR_APP_LO) begin
                addr_mapped = 1'b1;
            end else if (a == `ADDR_APP_HI) begin
                addr_mapped = 1'b1;
            end else if (a == `ADDR_APP_COMMIT) begin
                addr_mapped = 1'b1;
            end else if (a == `ADDR_REMOTE_RESET) begin
                addr_mapped = 1'b1;
            end else if (a == `ADDR_EXTREMES_CLEAR) begin
                addr_mapped = 1'b1;
            end else begin
                addr_mapped = 1'b0;
            end
        end
    endfunction

    // ******
    // Write handshake and staged values
    // ******
    // Writes stall while an answer is going out
    assign wr_ready    = ~resp_busy;
    assign wr_take     = wr_valid & wr_ready;
    assign commit_one  = (wr_data == `COMMIT_VALUE);
    assign lead_staged = {lead_hi_reg, lead_lo_reg};
    assign lag_staged  = {lag_hi_reg, lag_lo_reg};
    assign app_staged  = {app_hi_reg, app_lo_reg};
    assign reset_busy  = (reset_wait_reg != 32'h00000000);

    // Answer once per command, only if every word hit the map
    assign resp_start = wr_take & wr_last & ~cmd_bad_reg & addr_mapped(wr_addr);

    // ******
    // Range checks
    // ******
    preset_range_check u_lead_check (
        .preset_value  (lead_staged),
        .rated_power_w (rated_power_w),
        .in_range      (lead_ok)
    );

    preset_range_check u_lag_check (
        .preset_value  (lag_staged),
        .rated_power_w (rated_power_w),
        .in_range      (lag_ok)
    );

    preset_range_check u_app_check (
        .preset_value  (app_staged),
        .rated_power_w (rated_power_w),
        .in_range      (app_ok)
    );

    // ******
    // Acknowledgement sender
    // ******
    ok_response_tx u_resp (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .start       (resp_start),
        .station     (station),
        .tx_ready    (tx_ready),
        .tx_data_reg (tx_data),
        .tx_valid    (tx_valid),
        .busy        (resp_busy)
    );

    // ******
    // Command word bookkeeping
    // ******
    // Remember an unmapped word until the command ends
    always @(posedge clk) begin
        if (sys_rst) begin
            cmd_bad_reg <= 1'b0;
        end else if (wr_take) begin
            if (wr_last) begin
                cmd_bad_reg <= 1'b0;
            end else if (!addr_mapped(wr_addr)) begin
                cmd_bad_reg <= 1'b1;
            end
        end
    end

    // ******
    // Staging writes
    // ******
    // Staged words only sit here until a commit
    always @(posedge clk) begin
        if (sys_rst) begin
            lead_lo_reg <= `STAGE_RESET;
            lead_hi_reg <= `STAGE_RESET;
            lag_lo_reg  <= `STAGE_RESET;
            lag_hi_reg  <= `STAGE_RESET;
            app_lo_reg  <= `STAGE_RESET;
            app_hi_reg  <= `STAGE_RESET;
        end else if (wr_take) begin
            if (wr_addr == `ADDR_LEAD_LO) begin
                lead_lo_reg <= wr_data;
            end else if (wr_addr == `ADDR_LEAD_HI) begin
                lead_hi_reg <= wr_data;
            end else if (wr_addr == `ADDR_LAG_LO) begin
                lag_lo_reg <= wr_data;
            end else if (wr_addr == `ADDR_LAG_HI) begin
                lag_hi_reg <= wr_data;
            end else if (wr_addr == `ADDR_APP_LO) begin
                app_lo_reg <= wr_data;
            end else if (wr_addr == `ADDR_APP_HI) begin
                app_hi_reg <= wr_data;
            end
        end
    end

    // ******
    // Commits and reset actions
    // ******
    // One-cycle pulses; counters only move on a valid commit
    always @(posedge clk) begin
        if (sys_rst) begin
            lead_preset_reg     <= 32'h00000000;
            lag_preset_reg      <= 32'h00000000;
            apparent_preset_reg <= 32'h00000000;
            lead_load_reg       <= 1'b0;
            lag_load_reg        <= 1'b0;
            apparent_load_reg   <= 1'b0;
            preset_reject_reg   <= 1'b0;
            device_reset_reg    <= 1'b0;
            meas_clear_reg      <= 1'b0;
            opt_integ_stop_reg  <= 1'b0;
            extremes_clear_reg  <= 1'b0;
        end else begin
            lead_load_reg      <= 1'b0;
            lag_load_reg       <= 1'b0;
            apparent_load_reg  <= 1'b0;
            preset_reject_reg  <= 1'b0;
            device_reset_reg   <= 1'b0;
            meas_clear_reg     <= 1'b0;
            opt_integ_stop_reg <= 1'b0;
            extremes_clear_reg <= 1'b0;
            if (wr_take && commit_one) begin
                if (wr_addr == `ADDR_REACT_COMMIT) begin
                    lead_preset_reg   <= lead_staged;
                    lag_preset_reg    <= lag_staged;
                    lead_load_reg     <= lead_ok;
                    lag_load_reg      <= lag_ok;
                    preset_reject_reg <= ~(lead_ok & lag_ok);
                end else if (wr_addr == `ADDR_APP_COMMIT) begin
                    apparent_preset_reg <= app_staged;
                    apparent_load_reg   <= app_ok;
                    preset_reject_reg   <= ~app_ok;
                end else if (wr_addr == `ADDR_REMOTE_RESET) begin
                    // Energy loads and staging stay untouched
                    device_reset_reg   <= 1'b1;
                    meas_clear_reg     <= 1'b1;
                    opt_integ_stop_reg <= 1'b1;
                end else if (wr_addr == `ADDR_EXTREMES_CLEAR) begin
                    extremes_clear_reg <= 1'b1;
                end
            end
        end
    end

    // ******
    // Reset settling window
    // ******
    // Shows the host-facing quiet time after a remote reset
    always @(posedge clk) begin
        if (sys_rst) begin
            reset_wait_reg <= 32'h00000000;
        end else if (wr_take && commit_one && wr_addr == `ADDR_REMOTE_RESET) begin
            reset_wait_reg <= RESET_WAIT_CYCLES;
        end else if (reset_busy) begin
            reset_wait_reg <= reset_wait_reg - 32'h00000001;
        end
    end

    // ******
    // Register read
    // ******
    // Staging words read back; commit and reset words read zero
    always @(posedge clk) begin
        if (sys_rst) begin
            rd_data_reg <= `READ_ZERO;
            rd_ack_reg  <= 1'b0;
        end else begin
            rd_ack_reg <= rd_valid;
            if (!rd_valid) begin
                rd_data_reg <= rd_data_reg;
            end else if (rd_addr == `ADDR_LEAD_LO) begin
                rd_data_reg <= lead_lo_reg;
            end else if (rd_addr == `ADDR_LEAD_HI) begin
                rd_data_reg <= lead_hi_reg;
            end else if (rd_addr == `ADDR_LAG_LO) begin
                rd_data_reg <= lag_lo_reg;
            end else if (rd_addr == `ADDR_LAG_HI) begin
                rd_data_reg <= lag_hi_reg;
            end else if (rd_addr == `ADDR_APP_LO) begin
                rd_data_reg <= app_lo_reg;
            end else if (rd_addr == `ADDR_APP_HI) begin
                rd_data_reg <= app_hi_reg;
            end else begin
                rd_data_reg <= `READ_ZERO;
            end
        end
    end

endmodule // energy_preset_regs

`default_nettype wire

// [tb/host_link_model.sv]
// Host side byte sink that takes the acknowledgement stream with random stalls
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
    input  wire logic       clk,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output var  logic       tx_ready
);
    integer     seed = 21505;
    logic [7:0] rx_q [$];

    initial tx_ready = 1'b0;

    // Pick ready for the coming edge, then log the byte that edge takes
    always @(negedge clk) begin
        tx_ready = ($random(seed) % 3) != 0;
        if (tx_valid === 1'b1 && tx_ready) rx_q.push_back(tx_data);
    end
endmodule // host_link_model
`default_nettype wire

// [tb/energy_preset_regs_props.sv]
// Assertion checker for the energy preset register bank
`timescale 1ns/1ns
`default_nettype none
`include "energy_preset_defs.vh"
module energy_preset_regs_props #(
    parameter [31:0] RESET_WAIT_CYCLES = 32'h0000003C
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        wr_valid,
    input wire logic [15:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic        wr_last,
    input wire logic        wr_ready,
    input wire logic        tx_ready,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_valid,
    input wire logic        lead_load_reg,
    input wire logic        lag_load_reg,
    input wire logic        apparent_load_reg,
    input wire logic        device_reset_reg,
    input wire logic        meas_clear_reg,
    input wire logic        opt_integ_stop_reg,
    input wire logic        extremes_clear_reg,
    input wire logic        reset_busy
);
    // ******
    // Write decode helpers
    // ******
    wire logic taken  = wr_valid && wr_ready;
    wire logic one    = wr_data == `COMMIT_VALUE;
    wire logic mapped = wr_addr inside {[16'h0178:16'h017F], 16'h018F, `ADDR_EXTREMES_CLEAR};

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ******
    // Checks
    // ******
    a_react_bad_value: assert property (taken && wr_addr == `ADDR_REACT_COMMIT && !one
        |=> !lead_load_reg && !lag_load_reg) else $error("reactive load on invalid value");
    a_react_cause: assert property (lead_load_reg || lag_load_reg
        |-> $past(taken && wr_addr == `ADDR_REACT_COMMIT && one)) else $error("stray load");
    a_app_cause: assert property (apparent_load_reg
        |-> $past(taken && wr_addr == `ADDR_APP_COMMIT && one)) else $error("stray app load");
    a_remote_reset_fx: assert property (taken && wr_addr == `ADDR_REMOTE_RESET && one
        |=> device_reset_reg && meas_clear_reg && opt_integ_stop_reg) else $error("no reset");
    a_reset_keeps_energy: assert property (device_reset_reg
        |-> !(lead_load_reg || lag_load_reg || apparent_load_reg)) else $error("load on reset");
    a_busy_hold: assert property (device_reset_reg |-> reset_busy [*8])
        else $error("busy window too short");
    a_extremes_fires: assert property (taken && wr_addr == `ADDR_EXTREMES_CLEAR && one
        |=> extremes_clear_reg) else $error("extremes clear missing");
    a_extremes_cause: assert property (extremes_clear_reg
        |-> $past(taken && wr_addr == `ADDR_EXTREMES_CLEAR && one)) else $error("stray clear");
    a_frame_start: assert property ($rose(tx_valid)
        |-> tx_data == `CHAR_STX && $past(taken && wr_last)) else $error("bad frame start");
    a_unmapped_silent: assert property (taken && wr_last && !mapped |=> !tx_valid)
        else $error("reply to unmapped command");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte dropped while stalled");

    c_react: cover property (lead_load_reg && lag_load_reg);
    c_app: cover property (apparent_load_reg);
    c_reset: cover property (device_reset_reg);
endmodule // energy_preset_regs_props

bind energy_preset_regs energy_preset_regs_props #(
    .RESET_WAIT_CYCLES(RESET_WAIT_CYCLES)
) u_props (
    .clk(clk), .sys_rst(sys_rst), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_last(wr_last), .wr_ready(wr_ready), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .lead_load_reg(lead_load_reg), .lag_load_reg(lag_load_reg),
    .apparent_load_reg(apparent_load_reg), .device_reset_reg(device_reset_reg),
    .meas_clear_reg(meas_clear_reg), .opt_integ_stop_reg(opt_integ_stop_reg),
    .extremes_clear_reg(extremes_clear_reg), .reset_busy(reset_busy)
);
`default_nettype wire

// [tb/energy_preset_regs_test.sv]
// Self-checking bench of the energy preset register bank
`timescale 1ns/1ns
`default_nettype none
module energy_preset_regs_test;
    // ******
    // Stimulus, outputs and model state
    // ******
    localparam [31:0] WAIT_CYC = 32'h0000003C;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        wr_valid = 1'b0;
    logic        wr_last = 1'b0;
    logic        rd_valid = 1'b0;
    logic [15:0] wr_addr = 16'h0000;
    logic [15:0] wr_data = 16'h0000;
    logic [15:0] rd_addr = 16'h0000;
    logic [7:0]  station = 8'h01;
    logic [31:0] rated_power_w = 32'h00000000;
    wire logic        wr_ready, rd_ack_reg, tx_valid, tx_ready, lead_load_reg, lag_load_reg;
    wire logic        apparent_load_reg, preset_reject_reg, device_reset_reg, meas_clear_reg;
    wire logic        opt_integ_stop_reg, extremes_clear_reg, reset_busy;
    wire logic [15:0] rd_data_reg;
    wire logic [7:0]  tx_data;
    wire logic [31:0] lead_preset_reg, lag_preset_reg, apparent_preset_reg;
    integer      seed = 21505;
    integer      mismatches = 0;
    integer      total_checks = 0, n_busy = 0;
    integer      i, k, n_rej = 0, n_rst = 0, n_clr = 0, e_rej = 0, e_rst = 0, e_clr = 0;
    logic [15:0] stage [0:5];
    logic [15:0] sa [0:5] = '{16'h0178, 16'h0179, 16'h017A, 16'h017B, 16'h017D, 16'h017E};
    logic [31:0] pw [0:7] = '{32'h0001869F, 32'h000186A0, 32'h000F423F, 32'h000F4240,
                              32'h0098967F, 32'h00989680, 32'h00000000, 32'hFFFFFFFF};
    logic [31:0] q_lead [$], q_lag [$], q_app [$];
    logic [31:0] v;

    energy_preset_regs #(.RESET_WAIT_CYCLES(WAIT_CYC)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .wr_valid(wr_valid), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_last(wr_last), .wr_ready(wr_ready), .rd_valid(rd_valid),
        .rd_addr(rd_addr), .rd_data_reg(rd_data_reg), .rd_ack_reg(rd_ack_reg),
        .station(station), .tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .rated_power_w(rated_power_w), .lead_preset_reg(lead_preset_reg),
        .lead_load_reg(lead_load_reg), .lag_preset_reg(lag_preset_reg),
        .lag_load_reg(lag_load_reg), .apparent_preset_reg(apparent_preset_reg),
        .apparent_load_reg(apparent_load_reg), .preset_reject_reg(preset_reject_reg),
        .device_reset_reg(device_reset_reg), .meas_clear_reg(meas_clear_reg),
        .opt_integ_stop_reg(opt_integ_stop_reg), .extremes_clear_reg(extremes_clear_reg),
        .reset_busy(reset_busy)
    );
    host_link_model u_host (.clk(clk), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready));

    always #10 clk = ~clk;

    // ******
    // Helpers and reference model
    // ******
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    function automatic logic [31:0] lim(input logic [31:0] p);
        return p < 32'h000186A0 ? 32'h0001869F : p < 32'h000F4240 ? 32'h000F423F :
               p < 32'h00989680 ? 32'h0098967F : 32'h05F5E0FF;
    endfunction

    function automatic logic [31:0] pick(input logic [31:0] m);
        integer r;
        r = {$random(seed)} % 3;
        return r == 0 ? m : r == 1 ? m + 32'h1 : {$random(seed)} % (m + 32'h1);
    endfunction

    function automatic logic [7:0] hx(input logic [3:0] d);
        return d < 4'hA ? 8'h30 + d : 8'h37 + d;
    endfunction

    task automatic mdl(input logic [15:0] a, input logic [15:0] d);
        logic [31:0] m;
        m = lim(rated_power_w);
        for (int j = 0; j < 6; j++) if (a == sa[j]) stage[j] = d;
        if (a == 16'h017C && d == 16'h0001) begin
            if ({stage[1], stage[0]} <= m) q_lead.push_back({stage[1], stage[0]});
            if ({stage[3], stage[2]} <= m) q_lag.push_back({stage[3], stage[2]});
            if ({stage[1], stage[0]} > m || {stage[3], stage[2]} > m) e_rej++;
        end
        if (a == 16'h017F && d == 16'h0001) begin
            if ({stage[5], stage[4]} <= m) q_app.push_back({stage[5], stage[4]});
            else e_rej++;
        end
        if (a == 16'h018F && d == 16'h0001) e_rst++;
        if (a == 16'h015E && d == 16'h0001) e_clr++;
    endtask

    task automatic send(input logic [15:0] a, input logic [15:0] d, input logic l);
        integer n;
        @(negedge clk);
        for (n = 0; wr_ready !== 1'b1 && n < 100; n++) @(negedge clk);
        wr_valid = 1'b1;
        wr_addr = a;
        wr_data = d;
        wr_last = l;
        mdl(a, d);
        @(posedge clk);
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(negedge clk);
        rd_valid = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_valid = 1'b0;
        chk("rd_ack", 32'h1, rd_ack_reg);
        chk("rd_data", e, rd_data_reg);
    endtask

    task automatic frame(input logic want);
        logic [7:0] e [0:8];
        integer n;
        e = '{8'h02, hx(station[7:4]), hx(station[3:0]), 8'h30, 8'h31, 8'h4F, 8'h4B, 8'h03,
              8'h0D};
        @(negedge clk);
        wr_valid = 1'b0;
        for (n = 0; u_host.rx_q.size() < 9 && n < 300; n++) @(negedge clk);
        if (want) for (n = 0; n < 9; n++) chk("tx_byte", e[n], u_host.rx_q.pop_front());
        else chk("frame_size", 32'h0, u_host.rx_q.size());
    endtask

    // Counter loads and pulse tallies, sampled mid-cycle
    always @(negedge clk) begin
        if (lead_load_reg === 1'b1) chk("lead", q_lead.pop_front(), lead_preset_reg);
        if (lag_load_reg === 1'b1) chk("lag", q_lag.pop_front(), lag_preset_reg);
        if (apparent_load_reg === 1'b1) chk("app", q_app.pop_front(), apparent_preset_reg);
        n_rej += (preset_reject_reg === 1'b1);
        n_rst += ((device_reset_reg & meas_clear_reg & opt_integ_stop_reg) === 1'b1);
        n_clr += (extremes_clear_reg === 1'b1);
        n_busy += (reset_busy === 1'b1);
    end

    initial begin
        #400000;
        mismatches++;
        stop_test;
    end

    // ******
    // Main sequence
    // ******
    initial begin
        for (k = 0; k < 6; k++) stage[k] = 16'h0000;
        repeat (8) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        for (k = 0; k < 6; k++) rd(sa[k], 16'h0000);
        rd(16'h018F, 16'h0000);
        for (i = 0; i < 24; i++) begin
            rated_power_w = pw[i % 8];
            station = 8'($random(seed));
            for (k = 0; k < 6; k++) begin
                if (k % 2 == 0) v = pick(lim(rated_power_w));
                send(sa[k], k % 2 ? v[31:16] : v[15:0], 1'b0);
            end
            send(16'h017C, i % 5 == 4 ? 16'($random(seed)) : 16'h0001, 1'b0);
            send(16'h017F, i % 7 == 6 ? 16'h0002 : 16'h0001, 1'b1);
            frame(1'b1);
            for (k = 0; k < 6; k++) rd(sa[k], stage[k]);
            rd(16'h017C, 16'h0000);
        end
        send(16'h015E, 16'h0001, 1'b0);
        send(16'h015E, 16'h0003, 1'b1);
        frame(1'b1);
        send(16'h018F, 16'h0005, 1'b0);
        send(16'h018F, 16'h0001, 1'b1);
        frame(1'b1);
        chk("reset_busy", 32'h1, reset_busy);
        repeat (80) @(negedge clk);
        chk("reset_busy", 32'h0, reset_busy);
        chk("busy_len", WAIT_CYC, n_busy);
        for (k = 0; k < 6; k++) rd(sa[k], stage[k]);
        send(16'h0200, 16'h0001, 1'b0);
        send(16'h0178, 16'h0001, 1'b1);
        send(16'h0200, 16'h0001, 1'b1);
        frame(1'b0);
        chk("lead_left", 32'h0, q_lead.size() + q_lag.size() + q_app.size());
        chk("rejects", e_rej, n_rej);
        chk("resets", e_rst, n_rst);
        chk("clears", e_clr, n_clr);
        stop_test;
    end
endmodule // energy_preset_regs_test
`default_nettype wire
